/* File: rtl/sts_pkg.sv */
// Constants, register map and enumerations of the substrate shutter timing.
// Assumes one 10 MHz clock and register writes arriving over the serial port.
package sts_pkg;

	// Serial frame layout: address byte first, then data, both LSB first
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 24;
	localparam logic [5:0]  FRAME_BITS = 6'h20;

	// Register addresses
	localparam logic [7:0] ADR_TRIGGER   = 8'h60; // Exposure/readout starts
	localparam logic [7:0] ADR_READOUT   = 8'h61; // Readout field count
	localparam logic [7:0] ADR_SYNC_DIS  = 8'h62; // Sync output disable
	localparam logic [7:0] ADR_EXPOSURE  = 8'h63; // Long exposure fields
	localparam logic [7:0] ADR_PULSES    = 8'h64; // Pulses per field
	localparam logic [7:0] ADR_POLARITY  = 8'h66; // Start polarity
	localparam logic [7:0] ADR_FIRST_TOG = 8'h67; // First pulse toggles
	localparam logic [7:0] ADR_EXTRA_TOG = 8'h68; // Extra pulse toggles
	localparam logic [7:0] ADR_SUPPRESS  = 8'h69; // Lines withheld
	localparam logic [7:0] ADR_SEC_SEL   = 8'h6a; // Secondary input select
	localparam logic [7:0] ADR_OUT_SEL   = 8'h6b; // Shutter pin sources
	localparam logic [7:0] ADR_GATE_LINE = 8'h6c; // Sensor-gate line

	// Field positions
	localparam int unsigned TRIG_EXPOSE_BIT  = 3;
	localparam int unsigned TRIG_READOUT_BIT = 7;
	localparam int unsigned TOG_W            = 12; // One toggle position
	localparam int unsigned SEL_W            = 4;  // One pin source select

	// Reset values
	localparam logic [23:0] EXTRA_TOG_RST = 24'hffffff; // Extra pulse off
	localparam logic [23:0] FIRST_TOG_RST = 24'h000000;
	localparam logic [11:0] PULSES_RST    = 12'h001;
	localparam logic [11:0] ZERO12        = 12'h000;
	localparam logic [11:0] ONE12         = 12'h001;
	localparam logic [2:0]  ZERO3         = 3'h0;
	localparam logic [2:0]  ONE3          = 3'h1;
	localparam logic [3:0]  SEC_SEL_RST   = 4'h0;
	localparam logic [11:0] OUT_SEL_RST   = 12'h000;

	// Driver output levels
	typedef enum logic [1:0] {
		LVL_HIGH   = 2'b00,
		LVL_MID    = 2'b01,
		LVL_LOW    = 2'b10,
		LVL_LOWEST = 2'b11
	} sts_level_t;

	// Exposure sequencer
	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'b00,
		SEQ_EXPOSE  = 2'b01,
		SEQ_READOUT = 2'b10
	} sts_seq_t;

endpackage

/* File: rtl/sts_serial_if.sv */
// Write-only 3-wire serial register port.
// Assumes pins synchronous to mclk_i and a serial clock far below it.
module sts_serial_if (
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic        ser_load_n_i,
	input  wire logic        ser_clk_i,
	input  wire logic        ser_data_i,
	output logic             wr_en_o,
	output logic [7:0]       wr_addr_o,
	output logic [23:0]      wr_data_o
);

	logic        sck_q;    // Previous serial clock
	logic        load_q;   // Previous load level
	logic [31:0] shift_q;  // Frame shift register
	logic [5:0]  count_q;  // Bits taken in this frame

	// Edge history of the serial pins
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sck_q  <= 1'b1;
			load_q <= 1'b1;
		end else begin
			sck_q  <= ser_clk_i;
			load_q <= ser_load_n_i;
		end
	end

	// Shift on rising serial clock while load is low
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			shift_q <= 32'h00000000;
			count_q <= 6'h00;
		end else if (ser_load_n_i) begin
			count_q <= 6'h00;
		end else if (ser_clk_i && !sck_q && count_q != sts_pkg::FRAME_BITS) begin
			// Extra bits past a full frame are ignored
			shift_q <= {ser_data_i, shift_q[31:1]};
			count_q <= count_q + 6'h01;
		end
	end

	// Commit a complete frame when load returns high
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_en_o   <= 1'b0;
			wr_addr_o <= 8'h00;
			wr_data_o <= 24'h000000;
		end else begin
			wr_en_o <= ser_load_n_i && !load_q &&
			           count_q == sts_pkg::FRAME_BITS;
			if (ser_load_n_i && !load_q) begin
				wr_addr_o <= shift_q[7:0];
				wr_data_o <= shift_q[31:8];
			end
		end
	end

endmodule

/* File: rtl/sts_shutter_mux.sv */
// One shutter pin source selector with a registered output.
// Assumes the ten shutter sources are synchronous to mclk_i.
module sts_shutter_mux (
	input  wire logic       mclk_i,
	input  wire logic       reset_n_i,
	input  wire logic [9:0] sources_i,
	input  wire logic [3:0] select_i,
	output logic            pin_o
);

	// Codes above nine drive the pin low
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pin_o <= 1'b0;
		end else if (select_i < 4'ha) begin
			pin_o <= sources_i[select_i];
		end else begin
			pin_o <= 1'b0;
		end
	end

endmodule

/* File: rtl/sts_top.sv */
// Substrate clock shutter timing, secondary select, driver levels and
// shutter pin routing. Assumes line and field sync inputs are synchronous
// levels whose rising edges mark line and field starts.
// Operation
// - Phase ten/thirteen: low gives mid, high low
// - Substrate buffer three-level mapping from two inputs
// - Secondary input from sixteen-way selector
// - Selector resets to phase six
// - Pulse once per line, count from register
// - Polarity and toggle positions are programmable
// - Pulses start line after gate line
// - Shutter registers take effect after gate line
// - Extra pulse on last line in precision mode
// - Maximum extra toggle value disables extra pulse
// - Long exposure counter suppresses substrate and gate
// - Sync disable hides sync outputs during exposure
// - Exposure trigger starts at next field edge
// - Zero exposure count behaves like normal shuttering
// - Withhold pulses for programmed post-gate lines
// - Gate pulses every field unless suppressed
// - Readout fields keep suppressing after exposure
// - Six shutter sources assignable to three pins
// - Four XOR combinations offered as sources
// - Pulse count is twelve bits wide
// - Readout alone starts at next field edge
module sts_top #(
	parameter int unsigned PIX_W  = 12, // Pixel position width
	parameter int unsigned LINE_W = 12  // Line number width
) (
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic        ser_load_n_i,
	input  wire logic        ser_clk_i,
	input  wire logic        ser_data_i,
	input  wire logic        field_sync_i,
	input  wire logic        line_sync_i,
	input  wire logic        vert_phase_six_in_i,
	input  wire logic        vert_phase_eight_in_i,
	input  wire logic        vert_phase_nine_in_i,
	input  wire logic        vert_phase_ten_in_i,
	input  wire logic        vert_phase_thirteen_in_i,
	input  wire logic [7:0]  gate_pulse_i,
	input  wire logic [3:0]  shutter_pulse_i,
	input  wire logic [1:0]  bias_pulse_i,
	output logic             substrate_primary_in_o,
	output logic             substrate_secondary_in_o,
	output logic [1:0]       substrate_level_o,
	output logic [1:0]       vert_ten_level_o,
	output logic [1:0]       vert_thirteen_level_o,
	output logic [7:0]       sensor_gate_pulse_o,
	output logic             field_sync_o,
	output logic             line_sync_o,
	output logic             readout_bias_out_o,
	output logic             mech_shutter_out_o,
	output logic             strobe_out_o,
	output logic             exposure_active_o,
	output logic             readout_active_o
);

	// Positions are compared against twelve-bit toggle fields
	if (PIX_W != sts_pkg::TOG_W || LINE_W < 2) begin : g_check
		$error("sts_top: PIX_W must be 12 and LINE_W at least 2");
	end

	// True while pos lies between the two toggles
	function automatic logic in_window(input logic [11:0] pos,
	                                   input logic [23:0] tog);
		in_window = pos >= tog[11:0] && pos < tog[23:12];
	endfunction

	logic              wr_en;          // One-cycle register write
	logic [7:0]        wr_addr;        // Write address
	logic [23:0]       wr_data;        // Write data
	logic              field_q;        // Previous field sync
	logic              line_q;         // Previous line sync
	logic              vd_edge;        // Field start
	logic              hd_edge;        // Line start
	logic [PIX_W-1:0]  pix_q;          // Pixel position in line
	logic [LINE_W-1:0] line_num_q;     // Line number in field
	logic              after_gate;     // Line after gate line begins
	logic [2:0]        readout_cnt_q;  // Readout fields to suppress
	logic              sync_dis_q;     // Hide syncs during exposure
	logic [11:0]       exposure_cnt_q; // Long exposure fields
	logic [11:0]       pulses_q;       // Pulses per field, written
	logic              pol_q;          // Start polarity, written
	logic [23:0]       first_tog_q;    // First pulse toggles, written
	logic [23:0]       extra_tog_q;    // Extra pulse toggles, written
	logic [11:0]       suppress_q;     // Lines withheld, written
	logic [3:0]        sec_sel_q;      // Secondary input select
	logic [11:0]       out_sel_q;      // Three pin source selects
	logic [LINE_W-1:0] gate_line_q;    // Sensor-gate line number
	logic              sh_pol_q;       // Active copies, updated at the line after the gate line
	logic [23:0]       sh_first_q;
	logic [23:0]       sh_extra_q;
	logic [11:0]       sup_left_q;     // Withheld lines remaining
	logic [11:0]       pul_left_q;     // Pulses remaining in field
	logic [11:0]       sup_src;        // Counter view at this line start
	logic [11:0]       pul_src;
	logic              line_pulse_q;   // Current line carries a pulse
	logic              line_last_q;    // Current line has the last pulse
	logic              exp_pend_q;     // Exposure awaiting field edge
	logic              ro_pend_q;      // Readout awaiting field edge
	logic              exp_set;        // Trigger write requests
	logic              ro_set;
	logic              exp_take;       // Request consumed at field edge
	logic              ro_take;
	logic              go_expose;      // Sequencer decisions
	logic              go_readout;
	sts_pkg::sts_seq_t seq_q;          // Exposure sequencer state
	logic [11:0]       exp_left_q;     // Exposure fields remaining
	logic [2:0]        ro_left_q;      // Readout fields remaining
	logic              sub_supp;       // Substrate pulses suppressed
	logic              extra_on;       // Extra pulse enabled
	logic [15:0]       sec_sources;    // Secondary selector inputs
	logic [9:0]        shut_sources;   // Shutter pin sources
	logic [2:0]        shut_pins;      // Routed shutter pins

	// Serial register port
	sts_serial_if u_serial (
		.mclk_i       (mclk_i),
		.reset_n_i    (reset_n_i),
		.ser_load_n_i (ser_load_n_i),
		.ser_clk_i    (ser_clk_i),
		.ser_data_i   (ser_data_i),
		.wr_en_o      (wr_en),
		.wr_addr_o    (wr_addr),
		.wr_data_o    (wr_data)
	);

	// Register file; writes to unknown addresses are dropped
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			readout_cnt_q  <= sts_pkg::ZERO3;
			sync_dis_q     <= 1'b0;
			exposure_cnt_q <= sts_pkg::ZERO12;
			pulses_q       <= sts_pkg::PULSES_RST;
			pol_q          <= 1'b0;
			first_tog_q    <= sts_pkg::FIRST_TOG_RST;
			extra_tog_q    <= sts_pkg::EXTRA_TOG_RST;
			suppress_q     <= sts_pkg::ZERO12;
			sec_sel_q      <= sts_pkg::SEC_SEL_RST;
			out_sel_q      <= sts_pkg::OUT_SEL_RST;
			gate_line_q    <= '0;
		end else if (wr_en) begin
			unique case (wr_addr)
				sts_pkg::ADR_READOUT:   readout_cnt_q  <= wr_data[2:0];
				sts_pkg::ADR_SYNC_DIS:  sync_dis_q     <= wr_data[0];
				sts_pkg::ADR_EXPOSURE:  exposure_cnt_q <= wr_data[11:0];
				sts_pkg::ADR_PULSES:    pulses_q       <= wr_data[11:0];
				sts_pkg::ADR_POLARITY:  pol_q          <= wr_data[0];
				sts_pkg::ADR_FIRST_TOG: first_tog_q    <= wr_data;
				sts_pkg::ADR_EXTRA_TOG: extra_tog_q    <= wr_data;
				sts_pkg::ADR_SUPPRESS:  suppress_q     <= wr_data[11:0];
				sts_pkg::ADR_SEC_SEL:   sec_sel_q      <= wr_data[3:0];
				sts_pkg::ADR_OUT_SEL:   out_sel_q      <= wr_data[11:0];
				sts_pkg::ADR_GATE_LINE: gate_line_q    <= wr_data[LINE_W-1:0];
				default: ;
			endcase
		end
	end

	// Sync edge history
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			field_q <= 1'b0;
			line_q  <= 1'b0;
		end else begin
			field_q <= field_sync_i;
			line_q  <= line_sync_i;
		end
	end

	assign vd_edge    = field_sync_i && !field_q;
	assign hd_edge    = line_sync_i && !line_q;
	assign after_gate = hd_edge && !vd_edge &&
	                    line_num_q == gate_line_q;

	// Pixel position; saturates on an overlong line
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pix_q <= '0;
		end else if (hd_edge) begin
			pix_q <= '0;
		end else if (pix_q != {PIX_W{1'b1}}) begin
			pix_q <= pix_q + 1'b1;
		end
	end

	// Line number; a field edge wins over a coincident line edge
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			line_num_q <= '0;
		end else if (vd_edge) begin
			line_num_q <= '0;
		end else if (hd_edge) begin
			line_num_q <= line_num_q + 1'b1;
		end
	end

	// Waveform settings switch only at the line after the gate line,
	// so a write mid-field never bends a pulse already running
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sh_pol_q   <= 1'b0;
			sh_first_q <= sts_pkg::FIRST_TOG_RST;
			sh_extra_q <= sts_pkg::EXTRA_TOG_RST;
		end else if (after_gate) begin
			sh_pol_q   <= pol_q;
			sh_first_q <= first_tog_q;
			sh_extra_q <= extra_tog_q;
		end
	end

	// At the line after the gate line the counters load straight from
	// the written count and suppress values
	assign sup_src = after_gate ? suppress_q : sup_left_q;
	assign pul_src = after_gate ? pulses_q : pul_left_q;

	// Per-line pulse scheduling
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sup_left_q   <= sts_pkg::ZERO12;
			pul_left_q   <= sts_pkg::ZERO12;
			line_pulse_q <= 1'b0;
			line_last_q  <= 1'b0;
		end else if (vd_edge) begin
			// Nothing carries across a field boundary
			sup_left_q   <= sts_pkg::ZERO12;
			pul_left_q   <= sts_pkg::ZERO12;
			line_pulse_q <= 1'b0;
			line_last_q  <= 1'b0;
		end else if (hd_edge) begin
			if (sup_src != sts_pkg::ZERO12) begin
				// Withheld line
				sup_left_q   <= sup_src - sts_pkg::ONE12;
				pul_left_q   <= pul_src;
				line_pulse_q <= 1'b0;
				line_last_q  <= 1'b0;
			end else if (pul_src != sts_pkg::ZERO12) begin
				// One pulse in this line
				sup_left_q   <= sts_pkg::ZERO12;
				pul_left_q   <= pul_src - sts_pkg::ONE12;
				line_pulse_q <= 1'b1;
				line_last_q  <= pul_src == sts_pkg::ONE12;
			end else begin
				line_pulse_q <= 1'b0;
				line_last_q  <= 1'b0;
			end
		end
	end

	// Trigger requests; a new write wins over consumption
	assign exp_set = wr_en && wr_addr == sts_pkg::ADR_TRIGGER &&
	                 wr_data[sts_pkg::TRIG_EXPOSE_BIT];
	assign ro_set  = wr_en && wr_addr == sts_pkg::ADR_TRIGGER &&
	                 wr_data[sts_pkg::TRIG_READOUT_BIT];

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			exp_pend_q <= 1'b0;
			ro_pend_q  <= 1'b0;
		end else begin
			exp_pend_q <= exp_set || (exp_pend_q && !exp_take);
			ro_pend_q  <= ro_set || (ro_pend_q && !ro_take);
		end
	end

	// Sequencer decisions at a field edge; a zero exposure count is
	// taken and leaves shuttering untouched
	assign go_expose  = seq_q == sts_pkg::SEQ_IDLE && exp_pend_q &&
	                    exposure_cnt_q != sts_pkg::ZERO12;
	assign exp_take   = vd_edge && seq_q == sts_pkg::SEQ_IDLE && exp_pend_q;
	assign ro_take    = vd_edge && ro_pend_q &&
	                    ((seq_q == sts_pkg::SEQ_IDLE && !go_expose) ||
	                     (seq_q == sts_pkg::SEQ_EXPOSE &&
	                      exp_left_q == sts_pkg::ONE12));
	assign go_readout = ro_take && readout_cnt_q != sts_pkg::ZERO3;

	// Exposure and readout field counting
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			seq_q      <= sts_pkg::SEQ_IDLE;
			exp_left_q <= sts_pkg::ZERO12;
			ro_left_q  <= sts_pkg::ZERO3;
		end else if (vd_edge) begin
			unique case (seq_q)
				sts_pkg::SEQ_IDLE: begin
					if (go_expose) begin
						seq_q      <= sts_pkg::SEQ_EXPOSE;
						exp_left_q <= exposure_cnt_q;
					end else if (go_readout) begin
						seq_q     <= sts_pkg::SEQ_READOUT;
						ro_left_q <= readout_cnt_q;
					end
				end
				sts_pkg::SEQ_EXPOSE: begin
					exp_left_q <= exp_left_q - sts_pkg::ONE12;
					if (exp_left_q == sts_pkg::ONE12) begin
						if (go_readout) begin
							seq_q     <= sts_pkg::SEQ_READOUT;
							ro_left_q <= readout_cnt_q;
						end else begin
							seq_q <= sts_pkg::SEQ_IDLE;
						end
					end
				end
				sts_pkg::SEQ_READOUT: begin
					ro_left_q <= ro_left_q - sts_pkg::ONE3;
					if (ro_left_q == sts_pkg::ONE3) begin
						seq_q <= sts_pkg::SEQ_IDLE;
					end
				end
				default: seq_q <= sts_pkg::SEQ_IDLE;
			endcase
		end
	end

	assign sub_supp = seq_q != sts_pkg::SEQ_IDLE;
	assign extra_on = sh_extra_q != sts_pkg::EXTRA_TOG_RST;

	// Substrate primary drive; idles at the start polarity
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			substrate_primary_in_o <= 1'b0;
		end else begin
			substrate_primary_in_o <= sh_pol_q ^
				(line_pulse_q && !sub_supp &&
				 in_window(pix_q, sh_first_q)) ^
				(line_pulse_q && line_last_q && extra_on && !sub_supp &&
				 in_window(pix_q, sh_extra_q));
		end
	end

	// Gate pulses pass unless a long exposure runs
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sensor_gate_pulse_o <= 8'h00;
		end else if (seq_q == sts_pkg::SEQ_EXPOSE) begin
			sensor_gate_pulse_o <= 8'h00;
		end else begin
			sensor_gate_pulse_o <= gate_pulse_i;
		end
	end

	// Sync outputs, hidden during exposure when disabled
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			field_sync_o <= 1'b0;
			line_sync_o  <= 1'b0;
		end else if (sync_dis_q && seq_q == sts_pkg::SEQ_EXPOSE) begin
			field_sync_o <= 1'b0;
			line_sync_o  <= 1'b0;
		end else begin
			field_sync_o <= field_sync_i;
			line_sync_o  <= line_sync_i;
		end
	end

	// Secondary selector inputs in code order
	assign sec_sources = {strobe_out_o, mech_shutter_out_o,
	                      readout_bias_out_o, vert_phase_thirteen_in_i,
	                      gate_pulse_i[0], gate_pulse_i[3:1],
	                      gate_pulse_i[7:4],
	                      vert_phase_ten_in_i, vert_phase_nine_in_i,
	                      vert_phase_eight_in_i, vert_phase_six_in_i};

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			substrate_secondary_in_o <= 1'b0;
		end else begin
			substrate_secondary_in_o <= sec_sources[sec_sel_q];
		end
	end

	// Driver levels; one cycle behind their inputs
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			substrate_level_o     <= sts_pkg::LVL_HIGH;
			vert_ten_level_o      <= sts_pkg::LVL_MID;
			vert_thirteen_level_o <= sts_pkg::LVL_MID;
		end else begin
			if (!substrate_primary_in_o) begin
				substrate_level_o <= sts_pkg::LVL_HIGH;
			end else if (!substrate_secondary_in_o) begin
				substrate_level_o <= sts_pkg::LVL_MID;
			end else begin
				substrate_level_o <= sts_pkg::LVL_LOWEST;
			end
			vert_ten_level_o <= vert_phase_ten_in_i ?
				sts_pkg::LVL_LOW : sts_pkg::LVL_MID;
			vert_thirteen_level_o <= vert_phase_thirteen_in_i ?
				sts_pkg::LVL_LOW : sts_pkg::LVL_MID;
		end
	end

	// Shutter sources: six pulses, then four XOR mixes
	assign shut_sources = {
		shutter_pulse_i[0] ^ shutter_pulse_i[2],
		shutter_pulse_i[0] ^ shutter_pulse_i[1],
		shutter_pulse_i[0] ^ bias_pulse_i[1],
		shutter_pulse_i[0] ^ bias_pulse_i[0],
		bias_pulse_i, shutter_pulse_i};

	// Pin 0 bias, pin 1 mechanical shutter, pin 2 strobe
	for (genvar p = 0; p < 3; p++) begin : g_pin
		sts_shutter_mux u_mux (
			.mclk_i    (mclk_i),
			.reset_n_i (reset_n_i),
			.sources_i (shut_sources),
			.select_i  (out_sel_q[p*sts_pkg::SEL_W +: sts_pkg::SEL_W]),
			.pin_o     (shut_pins[p])
		);
	end

	assign readout_bias_out_o = shut_pins[0];
	assign mech_shutter_out_o = shut_pins[1];
	assign strobe_out_o       = shut_pins[2];
	assign exposure_active_o  = seq_q == sts_pkg::SEQ_EXPOSE;
	assign readout_active_o   = seq_q == sts_pkg::SEQ_READOUT;

endmodule

/* File: verification/sts_ccd_model.sv */
// Sensor side: free-running line and field sync, substrate pulse counter.
// Assumes the substrate drive changes only on rising clock edges.
module sts_ccd_model (
	input  wire logic  mclk_i,
	input  wire logic  sub_i,
	output logic       line_sync_o,
	output logic       field_sync_o,
	output logic [7:0] pulses_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned pix = 0;     // 40 clocks a line
	int unsigned ln = 0;      // 8 lines a field
	logic [7:0]  cnt = 8'h00; // Rising edges seen this field
	logic        sub_q = 1'b0;
	// Falling edges keep sync changes away from the sampling edge
	always @(negedge mclk_i) begin
		pix <= (pix == 39) ? 0 : pix + 1;
		if (pix == 39)
			ln <= (ln == 7) ? 0 : ln + 1;
		sub_q <= sub_i;
		if (pix == 39 && ln == 7) begin
			pulses_o <= cnt;
			cnt <= 8'h00;
		end else if (sub_i && !sub_q)
			cnt <= cnt + 8'h01;
	end
	assign line_sync_o = pix < 8;
	assign field_sync_o = line_sync_o && ln == 0;
endmodule

/* File: verification/sts_monitor.sv */
// Checker for sts_top, bound to every instance at the foot of this file.
// Assumes one clock and an asynchronous active low reset.
module sts_monitor (
	input wire logic       mclk_i,
	input wire logic       reset_n_i,
	input wire logic       vert_phase_ten_in_i,
	input wire logic [1:0] vert_ten_level_o,
	input wire logic       vert_phase_thirteen_in_i,
	input wire logic [1:0] vert_thirteen_level_o,
	input wire logic       line_sync_i,
	input wire logic       line_sync_o,
	input wire logic       substrate_primary_in_o,
	input wire logic       substrate_secondary_in_o,
	input wire logic [1:0] substrate_level_o,
	input wire logic [7:0] gate_pulse_i,
	input wire logic [7:0] sensor_gate_pulse_o,
	input wire logic       field_sync_i,
	input wire logic       field_sync_o,
	input wire logic       exposure_active_o,
	input wire logic       readout_active_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);
	a_ten_level: assert property (##1 vert_ten_level_o ==
		($past(vert_phase_ten_in_i) ? 2'h2 : 2'h1)) else $error("ten");
	a_thirteen_level: assert property (##1 vert_thirteen_level_o ==
		($past(vert_phase_thirteen_in_i) ? 2'h2 : 2'h1))
		else $error("thirteen");
	a_sub_level: assert property (##1 substrate_level_o ==
		(!$past(substrate_primary_in_o) ? 2'h0 :
		$past(substrate_secondary_in_o) ? 2'h3 : 2'h1)) else $error("lvl");
	a_gate_masked: assert property (exposure_active_o [*2] |->
		sensor_gate_pulse_o == 8'h00) else $error("gate mask");
	a_gate_follow: assert property (!exposure_active_o [*2] |->
		sensor_gate_pulse_o == $past(gate_pulse_i)) else $error("gate");
	a_sync_follow: assert property (!exposure_active_o [*2] |->
		field_sync_o == $past(field_sync_i)) else $error("sync");
	a_line_follow: assert property (!exposure_active_o [*2] |->
		line_sync_o == $past(line_sync_i)) else $error("line");
	// Start polarity is held while a sequence masks the pulses; three
	// cycles because the drive lags the state by one register
	a_sub_masked: assert property ((exposure_active_o ||
		readout_active_o) [*3] |-> $stable(substrate_primary_in_o))
		else $error("mask");
	a_seq_edge: assert property ($changed({exposure_active_o,
		readout_active_o}) |-> $past(field_sync_i)) else $error("edge");
	a_seq_excl: assert property (!(exposure_active_o &&
		readout_active_o)) else $error("excl");
	c_expose: cover property ($rose(exposure_active_o));
	c_readout: cover property ($rose(readout_active_o));
	c_pulse: cover property ($rose(substrate_primary_in_o));
endmodule
bind sts_top sts_monitor i_sts_monitor (.*);

/* File: verification/sts_top_tb_top.sv */
// Bench for sts_top: serial writes, sensor model sync, result checks.
// Assumes the package, design, monitor and model compile before it.
module sts_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        ld_n = 1'b1;    // Serial frame enable
	logic        sck = 1'b0;
	logic        sd = 1'b0;
	logic [12:0] src = 13'h0000; // Selector sources in code order
	logic [3:0]  shut = 4'h0;
	logic [1:0]  bias = 2'h0;
	logic [9:0]  psrc;           // Pin sources in code order
	logic [2:0]  pins;
	logic [7:0]  pulses;
	logic        fs, ls, pri, sec, fs_o, expo, rdo;
	int          error_cnt = 0;
	int          n_tests = 0;
	int          cyc = 0;
	always #50 mclk_i = ~mclk_i;
	sts_ccd_model i_sts_ccd_model (.mclk_i(mclk_i), .sub_i(pri),
		.line_sync_o(ls), .field_sync_o(fs), .pulses_o(pulses));
	sts_top i_sts_top (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.ser_load_n_i(ld_n), .ser_clk_i(sck), .ser_data_i(sd),
		.field_sync_i(fs), .line_sync_i(ls), .vert_phase_six_in_i(src[0]),
		.vert_phase_eight_in_i(src[1]), .vert_phase_nine_in_i(src[2]),
		.vert_phase_ten_in_i(src[3]), .vert_phase_thirteen_in_i(src[12]),
		.gate_pulse_i({src[7:4], src[10:8], src[11]}),
		.shutter_pulse_i(shut), .bias_pulse_i(bias),
		.substrate_primary_in_o(pri), .substrate_secondary_in_o(sec),
		.substrate_level_o(), .vert_ten_level_o(), .vert_thirteen_level_o(),
		.sensor_gate_pulse_o(), .field_sync_o(fs_o), .line_sync_o(),
		.readout_bias_out_o(pins[0]), .mech_shutter_out_o(pins[1]),
		.strobe_out_o(pins[2]), .exposure_active_o(expo),
		.readout_active_o(rdo));
	task automatic check(input string what, input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Frame of 32 bits, address then data, each bit held 2+2 clocks
	task automatic wr(input logic [7:0] adr, input logic [23:0] dat);
		logic [31:0] f;
		f = {dat, adr};
		ld_n = 1'b0;
		for (int i = 0; i < 32; i++) begin
			sd = f[i];
			sck = 1'b0;
			repeat (2) @(negedge mclk_i);
			sck = 1'b1;
			repeat (2) @(negedge mclk_i);
		end
		ld_n = 1'b1;
		repeat (3) @(negedge mclk_i);
	endtask
	task automatic fields(input int n);
		repeat (n) begin
			@(posedge fs);
			repeat (4) @(negedge mclk_i);
		end
	endtask
	// Trigger, then the sequencer state after each of four field edges
	task automatic run_seq(input logic [23:0] trig, input logic [7:0] s);
		wr(sts_pkg::ADR_TRIGGER, trig);
		for (int f = 0; f < 4; f++) begin
			fields(1);
			check("state", {6'h00, expo, rdo}, {6'h00, s[2*f+:2]});
			check("sync", {7'h00, fs_o}, {7'h00, !s[2*f+1]});
		end
	endtask
	// A hang counts as a mismatch
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		repeat (20) @(negedge mclk_i);
		reset_n_i = 1'b1;
		@(negedge mclk_i);
		// Code 0 runs on the reset value of the selector
		for (int k = 0; k < 13; k++) begin
			if (k > 0)
				wr(sts_pkg::ADR_SEC_SEL, 24'(k));
			src = 13'h0001 << k;
			repeat (3) @(negedge mclk_i);
			check("secondary", {7'h00, sec}, 8'h01);
			src = ~(13'h0001 << k);
			repeat (3) @(negedge mclk_i);
			check("secondary", {7'h00, sec}, 8'h00);
		end
		// Every source code on all three pins, over all shutter patterns
		for (int c = 0; c < 10; c++) begin
			wr(sts_pkg::ADR_OUT_SEL, {12'h000, 4'(c), 4'(c), 4'(c)});
			for (int p = 0; p < 16; p++) begin
				shut = 4'(p);
				bias = ~shut[1:0];
				psrc = {shut[0] ^ shut[2], shut[0] ^ shut[1],
					shut[0] ^ bias[1], shut[0] ^ bias[0], bias, shut};
				repeat (3) @(negedge mclk_i);
				check("pins", {5'h00, pins}, {5'h00, {3{psrc[c]}}});
			end
		end
		wr(sts_pkg::ADR_GATE_LINE, 24'h000002);
		wr(sts_pkg::ADR_SUPPRESS, 24'h000001);
		wr(sts_pkg::ADR_FIRST_TOG, 24'h00a005);
		for (int n = 1; n <= 4; n = n * 2) begin
			wr(sts_pkg::ADR_PULSES, 24'(n));
			fields(3);
			check("pulses", pulses, 8'(n));
		end
		wr(sts_pkg::ADR_EXTRA_TOG, 24'h01e014);
		fields(3);
		check("pulses", pulses, 8'h05);
		wr(sts_pkg::ADR_EXTRA_TOG, 24'hffffff);
		fields(3);
		check("pulses", pulses, 8'h04);
		wr(sts_pkg::ADR_SYNC_DIS, 24'h000001);
		wr(sts_pkg::ADR_READOUT, 24'h000001);
		wr(sts_pkg::ADR_EXPOSURE, 24'h000002);
		run_seq(24'h000088, 8'h1a);
		run_seq(24'h000080, 8'h01);
		wr(sts_pkg::ADR_EXPOSURE, 24'h000000);
		run_seq(24'h000008, 8'h00);
		check("pulses", pulses, 8'h04);
		final_report();
	end
endmodule
